// ===== dv/sfb_bank_one_asserts.sv
// Checker for the upper register bank: bus timing, indirect path, reset.
// Assumes a bind to sfb_bank_one; it sees only that module's ports.
`timescale 1ns/10ps
module sfb_bank_one_asserts (
  // Clock, reset and cause.
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        por_reset_i,
  input wire logic        bor_reset_i,
  input wire logic        wdt_reset_i,
  // Bus and memory side.
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [9:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        dmem_req_o,
  input wire logic        dmem_we_o,
  input wire logic [8:0]  dmem_adr_o,
  // Register contents.
  input wire logic [7:0]  status_o,
  input wire logic        pc_load_o,
  input wire logic [7:0]  option_o,
  input wire logic [7:0]  t2_period_o,
  input wire logic [5:0]  dir_a_o,
  input wire logic [7:0]  dir_e_o
);
  // Bus checks sleep in reset; reset checks key on its release instead.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////
  ack_one_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_has_req_a: assert property (wb_ack_o |-> $past(wb_stb_i))
    else $error("ack without request");
  read_upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  direct_latency_a: assert property ($rose(wb_stb_i) && wb_adr_i[8:2] != 7'h0 |=> wb_ack_o)
    else $error("direct answer late");
  indirect_path_a: assert property ($rose(wb_stb_i) && wb_adr_i[8:2] == 7'h0 |=> dmem_req_o && !wb_ack_o ##1 wb_ack_o)
    else $error("indirect sequence wrong");
  indirect_fields_a: assert property (dmem_req_o |-> dmem_we_o == wb_we_i && dmem_adr_o[8] == status_o[7])
    else $error("indirect request fields wrong");
  reset_values_a: assert property ($fell(rst_i) |-> option_o == 8'hff && t2_period_o == 8'hff && dir_a_o == 6'h3f && dir_e_o == 8'h07)
    else $error("reset value wrong");
  status_cause_a: assert property ($fell(rst_i) |-> status_o[7:3] == {3'b000, $past(por_reset_i | bor_reset_i | !wdt_reset_i), 1'b1})
    else $error("status reset bits wrong");
  dir_e_gap_a: assert property (dir_e_o[3] == 1'b0)
    else $error("unimplemented bit set");
  pc_load_write_a: assert property (pc_load_o |-> wb_ack_o && wb_we_i && wb_adr_i[8:2] == 7'h02)
    else $error("counter reload without low byte write");
  // Main scenarios that the bench must reach.
  cover property (dmem_req_o && dmem_we_o);
  cover property ($fell(rst_i) && $past(wdt_reset_i));
  cover property (wb_ack_o && wb_we_i);
endmodule : sfb_bank_one_asserts

// ===== dv/sfb_bank_one_tb.sv
// Self-checking bench for the upper register bank over classic Wishbone.
// Assumes package and checker compiled first; the bench plays the data memory.
`timescale 1ns/10ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fails++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module sfb_bank_one_tb;
  // Stimulus, observed signals and bookkeeping.
  logic        clk_i, rst_i, por_reset_i, bor_reset_i, wdt_reset_i, alu_flags_we_i;
  logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, dmem_req_o, dmem_we_o;
  logic [9:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, r;
  logic [8:0]  dmem_adr_o;
  logic [7:0]  dmem_wdat_o, dmem_rdat_i, m, e;
  logic [7:0]  mem [512];
  logic [7:0]  exp_q [$], msk_q [$];
  logic [2:0]  alu_flags_i;
  logic [5:0]  ssp_state_i;
  int          fails, cmp_count;
  integer      seed;
  localparam logic [7:0] RIX [17] = '{8'h81, 8'h82, 8'h85, 8'h86, 8'h87, 8'h88, 8'h89, 8'h8a, 8'h8c,
    8'h8d, 8'h8f, 8'h90, 8'h91, 8'h92, 8'h93, 8'h95, 8'h96};
  localparam logic [7:0] RVL [17] = '{8'hff, 8'h00, 8'h3f, 8'hff, 8'hff, 8'hff, 8'h07, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] WIX [13] = '{8'h81, 8'h82, 8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h8a, 8'h8b, 8'h8c,
    8'h8d, 8'h92, 8'h93};
  localparam logic [7:0] WMK [13] = '{8'hff, 8'hff, 8'hff, 8'h3f, 8'hff, 8'hff, 8'hff, 8'h1f, 8'hff, 8'hff,
    8'h01, 8'hff, 8'hff};

  sfb_bank_one sfb_bank_one_i (.clk_i, .rst_i, .por_reset_i, .bor_reset_i, .wdt_reset_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .dmem_req_o, .dmem_we_o,
    .dmem_adr_o, .dmem_wdat_o, .dmem_rdat_i, .alu_flags_we_i, .alu_flags_i, .irq_flags_set_i(3'h0),
    .psp_in_full_i(1'b0), .psp_out_full_i(1'b0), .psp_overflow_i(1'b0), .ssp_state_i, .status_o(),
    .option_o(), .pc_low_byte_o(), .pc_high_latch_o(), .pc_load_o(), .intctl_o(), .pie_one_o(),
    .pie_two_o(), .t2_period_o(), .ssp_addr_o(), .dir_a_o(), .dir_b_o(), .dir_c_o(), .dir_d_o(), .dir_e_o());
  ////////////////////////////////////////////////////////////
  // Free-running 10 MHz clock.
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // Data memory: the design takes read data at the edge that ends its request
  // cycle, so the array is read combinationally; while idle the bus wanders.
  logic [7:0]  junk = 8'h00;
  assign dmem_rdat_i = (dmem_req_o === 1'b1) ? mem[dmem_adr_o] : junk;
  always @(posedge clk_i)
  begin
    if (dmem_req_o === 1'b1 && dmem_we_o === 1'b1) mem[dmem_adr_o] <= dmem_wdat_o;
    junk <= ~junk;
  end

  // Each read answer is compared with the oldest note; writes leave no note.
  always @(posedge clk_i)
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
    begin
      m = msk_q.pop_front();
      e = exp_q.pop_front();
      `CHK(wb_dat_o & {24'h0, m}, {24'h0, e & m})
    end

  // Reset with a given cause held steady for 16 cycles.
  task automatic rst_seq(input logic [2:0] c);
    @(posedge clk_i);
    rst_i <= 1'b1;
    {por_reset_i, bor_reset_i, wdt_reset_i} <= c;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    {por_reset_i, bor_reset_i, wdt_reset_i} <= 3'b000;
  endtask : rst_seq

  // One classic cycle; a write with mask zero is sent with lane zero off.
  task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] v, input logic [7:0] mk);
    int n;
    if (!w) exp_q.push_back(v);
    if (!w) msk_q.push_back(mk);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= (w && mk == 8'h00) ? 4'h0 : 4'hf;
    wb_dat_i <= {24'h0, v};
    // Ack is looked at only on rising edges; the request is released there.
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    if (wb_ack_o !== 1'b1)
    begin
      fails++;
      report_and_stop();
    end
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask : acc

  // Reset values of the table, all columns alike.
  task automatic table_check();
    for (int k = 0; k < 17; k++) acc(1'b0, RIX[k], RVL[k], 8'hff);
  endtask : table_check

  // Prints counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    seed = 32'hb4663a69;
    {rst_i, por_reset_i, bor_reset_i, wdt_reset_i, alu_flags_we_i, wb_cyc_i, wb_stb_i, wb_we_i} = 8'hc0;
    {wb_adr_i, wb_sel_i, wb_dat_i, alu_flags_i} = '0;
    r = $random(seed);
    ssp_state_i = r[5:0];
    rst_seq(3'b100);
    table_check();
    acc(1'b0, 8'h83, 8'h18, 8'hf8);
    acc(1'b0, 8'h03, 8'h18, 8'hf8);
    acc(1'b0, 8'h8e, 8'h00, 8'h02);
    acc(1'b0, 8'h94, {2'b00, ssp_state_i}, 8'hff);
    $display("power-up values done");
    for (int k = 0; k < 13; k++)
    begin
      r = $random(seed);
      if (WIX[k] == 8'h8c) r[6] = 1'b0;
      acc(1'b1, WIX[k], r[7:0], 8'hff);
      acc(1'b0, WIX[k], r[7:0] & WMK[k], 8'hff);
    end
    acc(1'b1, 8'h81, 8'h3c, 8'hff);
    acc(1'b1, 8'h81, 8'hc3, 8'h00);
    acc(1'b0, 8'h81, 8'h3c, 8'hff);
    acc(1'b1, 8'h90, 8'hff, 8'hff);
    acc(1'b0, 8'h90, 8'h00, 8'hff);
    acc(1'b1, 8'h0a, 8'h1b, 8'hff);
    acc(1'b0, 8'h8a, 8'h1b, 8'hff);
    acc(1'b0, 8'h01, 8'h00, 8'hff);
    $display("write and mirror done");
    acc(1'b1, 8'h83, 8'h00, 8'hff);
    for (int k = 0; k < 4; k++)
    begin
      r = $random(seed);
      acc(1'b1, k[0] ? 8'h04 : 8'h84, r[15:8], 8'hff);
      acc(1'b1, k[0] ? 8'h00 : 8'h80, r[7:0], 8'hff);
      `CHK(mem[{1'b0, r[15:8]}], r[7:0])
      acc(1'b0, k[0] ? 8'h80 : 8'h00, r[7:0], 8'hff);
    end
    @(posedge clk_i);
    {alu_flags_we_i, alu_flags_i} <= {1'b1, r[18:16]};
    @(posedge clk_i);
    alu_flags_we_i <= 1'b0;
    acc(1'b0, 8'h83, {5'h00, r[18:16]}, 8'h07);
    $display("indirect and flags done");
    acc(1'b1, 8'h8e, 8'h03, 8'hff);
    rst_seq(3'b001);
    table_check();
    acc(1'b0, 8'h83, 8'h08, 8'hf8);
    acc(1'b0, 8'h8e, 8'h03, 8'h03);
    rst_seq(3'b010);
    acc(1'b0, 8'h83, 8'h18, 8'hf8);
    acc(1'b0, 8'h8e, 8'h02, 8'h03);
    @(posedge clk_i);
    @(posedge clk_i);
    `CHK(exp_q.size(), 0)
    $display("later resets done");
    report_and_stop();
  end
endmodule : sfb_bank_one_tb

bind sfb_bank_one sfb_bank_one_asserts sfb_bank_one_asserts_i (.clk_i, .rst_i, .por_reset_i, .bor_reset_i,
  .wdt_reset_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .dmem_req_o, .dmem_we_o, .dmem_adr_o,
  .status_o, .pc_load_o, .option_o, .t2_period_o, .dir_a_o, .dir_e_o);

// ===== verilog/sfb_bank_one.sv
// Upper bank special function registers behind a classic Wishbone slave.
// Assumes one clock, a synchronous reset with the reset cause valid while it
// is high, and a data memory that answers combinationally within the request cycle.
// Function
// RULE1 - Unimplemented locations and bits read zero
// RULE2 - Holding latch buffers program counter bits 12:8
// RULE3 - Software keeps reserved bank bits cleared
// RULE4 - Non power-up resets use second reset column; brown-out uses the first here
// RULE5 - Core registers shared between both banks
// RULE6 - Indirect port accesses memory through pointer
// RULE7 - Software clears absent port and PSP bits
// RULE8 - Software clears absent converter bits
// RULE9 - Unknown bits undefined, unchanged bits keep value
// RULE10 - Status holds flags, reset cause, bank bit
// RULE11 - Decode 80h to 95h, one-cycle read data; the indirect port takes two cycles here
// RULE12 - Reset values loaded as reset is released
`timescale 1ns/10ps
module sfb_bank_one
  import sfb_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Reset cause, valid while rst_i is high.
  input  wire logic        por_reset_i,
  input  wire logic        bor_reset_i,
  input  wire logic        wdt_reset_i,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Data memory for the indirect port.
  output logic             dmem_req_o,
  output logic             dmem_we_o,
  output logic      [8:0]  dmem_adr_o,
  output logic      [7:0]  dmem_wdat_o,
  input  wire logic [7:0]  dmem_rdat_i,
  // Core and peripheral status.
  input  wire logic        alu_flags_we_i,
  input  wire logic [2:0]  alu_flags_i,
  input  wire logic [2:0]  irq_flags_set_i,
  input  wire logic        psp_in_full_i,
  input  wire logic        psp_out_full_i,
  input  wire logic        psp_overflow_i,
  input  wire logic [5:0]  ssp_state_i,
  // Register contents toward the core and peripherals.
  output logic      [7:0]  status_o,
  output logic      [7:0]  option_o,
  output logic      [7:0]  pc_low_byte_o,
  output logic      [4:0]  pc_high_latch_o,
  output logic             pc_load_o,
  output logic      [7:0]  intctl_o,
  output logic      [7:0]  pie_one_o,
  output logic             pie_two_o,
  output logic      [7:0]  t2_period_o,
  output logic      [7:0]  ssp_addr_o,
  output logic      [5:0]  dir_a_o,
  output logic      [7:0]  dir_b_o,
  output logic      [7:0]  dir_c_o,
  output logic      [7:0]  dir_d_o,
  output logic      [7:0]  dir_e_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode.

  sfb_state_t state;
  logic [7:0] idx;
  logic [7:0] folded;
  logic [7:0] wbyte;
  logic       req;
  logic       shared;
  logic       is_ind;
  logic       wr;
  logic       cold;
  logic [7:0] rd_mux;
  logic [1:0] pwr_flags;

  // Locations shared by both banks are folded onto their upper-bank index.
  // The test works on the raw address so that it never loops through idx.
  assign folded = {1'b1, wb_adr_i[8:2]};
  assign shared = (folded == IDX_INDIRECT) || (folded == IDX_PC_LOW) || (folded == IDX_STATUS)
               || (folded == IDX_POINTER) || (folded == IDX_PC_HIGH) || (folded == IDX_INTCTL);
  always_comb
  begin
    idx = wb_adr_i[9:2];
    if (!wb_adr_i[9])
    begin
      idx = folded;  // RULE5
      if (!shared)
      begin
        idx = 8'h00;
      end
    end
  end

  assign wbyte  = wb_dat_i[7:0];
  assign req    = wb_cyc_i && wb_stb_i && (state == ST_IDLE);
  assign is_ind = (idx == IDX_INDIRECT);
  // Only the low byte lane carries data; other lanes alone write nothing.
  assign wr     = req && wb_we_i && wb_sel_i[0] && !is_ind;
  // Power-up and brown-out resets select the first reset column.
  assign cold   = por_reset_i || bor_reset_i;

  ////////////////////////////////////////////////////////////////////////////
  // Plain read/write registers.

  // Each register loads its column value for as long as reset is held.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      option_o        <= RST_OPTION;  // RULE12
      pc_low_byte_o   <= RST_PC_LOW;
      pc_high_latch_o <= RST_PC_HIGH;
      pie_one_o       <= RST_PIE_ONE;
      pie_two_o       <= RST_PIE_TWO;
      t2_period_o     <= RST_T2_PERIOD;
      ssp_addr_o      <= RST_SSP_ADDR;
      dir_a_o         <= RST_DIR_A;
      dir_b_o         <= RST_DIR_FULL;
      dir_c_o         <= RST_DIR_FULL;
      dir_d_o         <= RST_DIR_FULL;
    end
    else if (wr)
    begin
      unique case (idx)
        IDX_OPTION:    option_o        <= wbyte;
        IDX_PC_LOW:    pc_low_byte_o   <= wbyte;
        IDX_PC_HIGH:   pc_high_latch_o <= wbyte[4:0];  // RULE2
        IDX_PIE_ONE:   pie_one_o       <= wbyte;
        IDX_PIE_TWO:   pie_two_o       <= wbyte[0];
        IDX_T2_PERIOD: t2_period_o     <= wbyte;
        IDX_SSP_ADDR:  ssp_addr_o      <= wbyte;
        IDX_DIR_A:     dir_a_o         <= wbyte[5:0];
        IDX_DIR_B:     dir_b_o         <= wbyte;
        IDX_DIR_C:     dir_c_o         <= wbyte;
        IDX_DIR_D:     dir_d_o         <= wbyte;
        default:       ;  // RULE1
      endcase
    end
  end

  // A write to the low program counter byte tells the core to reload the
  // whole counter, taking bits 12:8 from the holding latch.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pc_load_o <= 1'b0;
    end
    else
    begin
      pc_load_o <= wr && (idx == IDX_PC_LOW);  // RULE2
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic status.

  // Bank bits clear on every reset; time-out comes from the reset cause, power-down
  // sets on any reset, and neither is writable. The ALU flags have no reset value
  // and an ALU update wins over a bus write in the same cycle.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      status_o[7:5]        <= RST_ST_BANKS;  // RULE12
      status_o[ST_TIMEOUT] <= cold || !wdt_reset_i;  // RULE4
      status_o[ST_PWR_DOWN] <= 1'b1;  // RULE9
    end
    else if (wr && (idx == IDX_STATUS))
    begin
      status_o[7:5] <= wbyte[7:5];  // RULE10
    end
    if (!rst_i && alu_flags_we_i)
    begin
      status_o[2:0] <= alu_flags_i;  // RULE10
    end
    else if (wr && (idx == IDX_STATUS))
    begin
      status_o[2:0] <= wbyte[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pointer, interrupt control and reset-cause flags.

  // The pointer has no reset value; it keeps its contents over any reset.
  logic [7:0] pointer;
  always_ff @(posedge clk_i)
  begin
    if (wr && !rst_i && (idx == IDX_POINTER))
    begin
      pointer <= wbyte;  // RULE9
    end
  end

  // The upper control bits reset; the external interrupt flag is left as it
  // was. Hardware flag events win over a software write in the same cycle.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      intctl_o[7:1] <= RST_INTCTL_HI;  // RULE9
    end
    else
    begin
      if (wr && (idx == IDX_INTCTL))
      begin
        intctl_o[7:1] <= wbyte[7:1];
      end
      if (irq_flags_set_i[2])
      begin
        intctl_o[2] <= 1'b1;
      end
      if (irq_flags_set_i[1])
      begin
        intctl_o[1] <= 1'b1;
      end
    end
    if (!rst_i && irq_flags_set_i[0])
    begin
      intctl_o[0] <= 1'b1;
    end
    else if (!rst_i && wr && (idx == IDX_INTCTL))
    begin
      intctl_o[0] <= wbyte[0];
    end
  end

  // A flag drops on its own reset cause, otherwise keeps its value.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      if (por_reset_i)
      begin
        pwr_flags[1] <= 1'b0;  // RULE9
      end
      if (bor_reset_i)
      begin
        pwr_flags[0] <= 1'b0;
      end
    end
    else if (wr && (idx == IDX_PWR_FLAGS))
    begin
      pwr_flags <= wbyte[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port E direction, parallel port status and serial port state.

  // The overflow flag is sticky; a new overflow wins over a software clear.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dir_e_o <= RST_DIR_E;  // RULE4
    end
    else
    begin
      dir_e_o[PE_IN_FULL]  <= psp_in_full_i;
      dir_e_o[PE_OUT_FULL] <= psp_out_full_i;
      dir_e_o[3]           <= 1'b0;  // RULE1
      if (psp_overflow_i)
      begin
        dir_e_o[PE_IN_OVF] <= 1'b1;
      end
      else if (wr && (idx == IDX_DIR_E))
      begin
        dir_e_o[PE_IN_OVF] <= wbyte[PE_IN_OVF];
      end
      if (wr && (idx == IDX_DIR_E))
      begin
        dir_e_o[PE_PSP_MODE] <= wbyte[PE_PSP_MODE];
        dir_e_o[2:0]         <= wbyte[2:0];
      end
    end
  end

  // The serial port state is read only; it is sampled from the port.
  logic [5:0] ssp_state;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ssp_state <= RST_SSP_STATE;
    end
    else
    begin
      ssp_state <= ssp_state_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read multiplexer.

  // Anything not listed, and any unused upper bit, reads as zero.
  always_comb
  begin
    rd_mux = 8'h00;  // RULE1
    unique case (idx)
      IDX_OPTION:    rd_mux = option_o;
      IDX_PC_LOW:    rd_mux = pc_low_byte_o;
      IDX_STATUS:    rd_mux = status_o;
      IDX_POINTER:   rd_mux = pointer;
      IDX_DIR_A:     rd_mux = {2'h0, dir_a_o};
      IDX_DIR_B:     rd_mux = dir_b_o;
      IDX_DIR_C:     rd_mux = dir_c_o;
      IDX_DIR_D:     rd_mux = dir_d_o;
      IDX_DIR_E:     rd_mux = dir_e_o;
      IDX_PC_HIGH:   rd_mux = {3'h0, pc_high_latch_o};
      IDX_INTCTL:    rd_mux = intctl_o;
      IDX_PIE_ONE:   rd_mux = pie_one_o;
      IDX_PIE_TWO:   rd_mux = {7'h00, pie_two_o};
      IDX_PWR_FLAGS: rd_mux = {6'h00, pwr_flags};
      IDX_T2_PERIOD: rd_mux = t2_period_o;
      IDX_SSP_ADDR:  rd_mux = ssp_addr_o;
      IDX_SSP_STATE: rd_mux = {2'h0, ssp_state};
      default:       rd_mux = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus sequencer.

  // Direct registers answer one cycle after the request. The indirect port
  // needs a second cycle for the memory round trip, traded for not keeping a
  // copy of memory here.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state       <= ST_IDLE;
      wb_ack_o    <= 1'b0;
      wb_dat_o    <= 32'h0000_0000;
      dmem_req_o  <= 1'b0;
      dmem_we_o   <= 1'b0;
      dmem_adr_o  <= 9'h000;
      dmem_wdat_o <= 8'h00;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
        begin
          if (req && is_ind)
          begin
            dmem_req_o  <= 1'b1;  // RULE6
            dmem_we_o   <= wb_we_i && wb_sel_i[0];
            dmem_adr_o  <= {status_o[ST_IND_BANK], pointer};
            dmem_wdat_o <= wbyte;
            state       <= ST_MEM;
          end
          else if (req)
          begin
            wb_dat_o <= {24'h00_0000, rd_mux};  // RULE11
            wb_ack_o <= 1'b1;
            state    <= ST_DONE;
          end
        end
        ST_MEM:
        begin
          dmem_req_o <= 1'b0;
          dmem_we_o  <= 1'b0;
          wb_dat_o   <= dmem_we_o ? 32'h0000_0000 : {24'h00_0000, dmem_rdat_i};  // RULE6
          wb_ack_o   <= 1'b1;
          state      <= ST_DONE;
        end
        ST_DONE:
        begin
          wb_ack_o <= 1'b0;
          state    <= ST_IDLE;
        end
      endcase
    end
  end

endmodule : sfb_bank_one

// ===== verilog/sfb_pkg.sv
// Constants of the upper special function register bank: register indexes,
// field positions, reset values and the bus sequencer states.
// Assumes a 32-bit Wishbone bus whose byte address is four times the index.
package sfb_pkg;

  // Register indexes; the byte address is four times the index.
  localparam logic [7:0] IDX_INDIRECT  = 8'h80;
  localparam logic [7:0] IDX_OPTION    = 8'h81;
  localparam logic [7:0] IDX_PC_LOW    = 8'h82;
  localparam logic [7:0] IDX_STATUS    = 8'h83;
  localparam logic [7:0] IDX_POINTER   = 8'h84;
  localparam logic [7:0] IDX_DIR_A     = 8'h85;
  localparam logic [7:0] IDX_DIR_B     = 8'h86;
  localparam logic [7:0] IDX_DIR_C     = 8'h87;
  localparam logic [7:0] IDX_DIR_D     = 8'h88;
  localparam logic [7:0] IDX_DIR_E     = 8'h89;
  localparam logic [7:0] IDX_PC_HIGH   = 8'h8a;
  localparam logic [7:0] IDX_INTCTL    = 8'h8b;
  localparam logic [7:0] IDX_PIE_ONE   = 8'h8c;
  localparam logic [7:0] IDX_PIE_TWO   = 8'h8d;
  localparam logic [7:0] IDX_PWR_FLAGS = 8'h8e;
  localparam logic [7:0] IDX_T2_PERIOD = 8'h92;
  localparam logic [7:0] IDX_SSP_ADDR  = 8'h93;
  localparam logic [7:0] IDX_SSP_STATE = 8'h94;
  localparam logic [7:0] BANK_MASK     = 8'h7f;

  // Arithmetic status field positions.
  localparam int ST_IND_BANK = 7;
  localparam int ST_UPPER    = 6;
  localparam int ST_BANK_SEL = 5;
  localparam int ST_TIMEOUT  = 4;
  localparam int ST_PWR_DOWN = 3;

  // Port E direction and parallel port status field positions.
  localparam int PE_IN_FULL  = 7;
  localparam int PE_OUT_FULL = 6;
  localparam int PE_IN_OVF   = 5;
  localparam int PE_PSP_MODE = 4;

  // Reset values.
  localparam logic [7:0] RST_OPTION    = 8'hff;
  localparam logic [7:0] RST_PC_LOW    = 8'h00;
  localparam logic [5:0] RST_DIR_A     = 6'h3f;
  localparam logic [7:0] RST_DIR_FULL  = 8'hff;
  localparam logic [7:0] RST_DIR_E     = 8'h07;
  localparam logic [4:0] RST_PC_HIGH   = 5'h00;
  localparam logic [6:0] RST_INTCTL_HI = 7'h00;
  localparam logic [7:0] RST_PIE_ONE   = 8'h00;
  localparam logic       RST_PIE_TWO   = 1'b0;
  localparam logic [7:0] RST_T2_PERIOD = 8'hff;
  localparam logic [7:0] RST_SSP_ADDR  = 8'h00;
  localparam logic [5:0] RST_SSP_STATE = 6'h00;
  localparam logic [2:0] RST_ST_BANKS  = 3'h0;

  // Bus sequencer states.
  typedef enum logic [1:0] {ST_IDLE, ST_MEM, ST_DONE} sfb_state_t;

endpackage : sfb_pkg
